// file: hw/usbep_ctrl.sv
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/10ps
// Notes on behaviour
// - protocol error: stall, flag, interrupt
// - token after data end is error
// - oversize out data packet is error
// - nonzero status data1 is error
// - send stall request stalls, sets flag
// - unexpected token sets abort, goes idle
// - setup accepted only with eight bytes
// - received packet sets rx ready, interrupt
// - release enters tx or rx by direction
// - tx takes in only, rx out only
// - 32-byte packets, short packet ends
// - sent in packet clears tx ready, interrupt; code clears tx ready only in EP0_TX, not in EP0_STATUS_IN
// - data end with tx ready starts status
// - in without tx ready gets nak
// - rx count valid while rx ready
// - per direction iso or bulk type
// - fifo sizes 32 to 512 bytes
// - single buffer sum within fifo
// - double buffer sum within half
// - control endpoint fixed 32, single buffer
// - enable low resets controller
module usbep_ctrl
    import usbep_pkg::*;
(
    input wire logic MCLK,
    input wire logic RSTN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic TOK_VALID,
    input wire logic [1:0] TOK_PID,
    input wire logic TOK_DATA1,
    input wire logic [9:0] TOK_LEN,
    input wire logic SETUP_DIR_IN,
    input wire logic SETUP_HAS_DATA,
    input wire logic TX_DONE,
    output logic [1:0] HS_CODE,
    output logic HS_VALID,
    output logic EP0_IRQ
);
    logic ena_q;
    logic irq_en_q;
    logic [2:0] sel_q;
    logic rx_ready_q, tx_ready_q, sent_stall_q, data_end_q, aborted_q, send_stall_q;
    logic [9:0] rx_count_q;
    logic dir_in_q, has_data_q;
    logic [1:0] hs_d, hs_q;
    logic hs_v_q;
    logic irq_q, ev;
    usbep_state_t st_q;
    logic [9:0] in_max [NUM_EP];
    logic [9:0] out_max [NUM_EP];
    logic [1:0] in_cfg [NUM_EP];
    logic [1:0] out_cfg [NUM_EP];
    logic [NUM_EP-1:0] lay_ok;
    logic [9:0] tok_len_s;
    logic [3:0] tok_s;
    logic tx_done_s, tx_done_p;
    logic tok_v_p, tok_v_prev;
    logic setup_in_s, setup_data_s;
    logic acc, wr;
    logic tok_in, tok_out, tok_setup;
    logic err, stall_send, nak, ok_rx, abort;
    logic release_w, data_end_w, stall_w, abort_clr_w;
    logic [31:0] rd_d;
    logic [2:0] idx;

    // token, setup and tx done inputs pass two flip-flops
    usbep_sync #(.W(4)) u_sync_tok (
        .clk(MCLK), .rst_n(RSTN),
        .d({TOK_VALID, TOK_PID, TOK_DATA1}), .q(tok_s)
    );
    usbep_sync #(.W(13)) u_sync_misc (
        .clk(MCLK), .rst_n(RSTN),
        .d({TOK_LEN, SETUP_DIR_IN, SETUP_HAS_DATA, TX_DONE}),
        .q({tok_len_s, setup_in_s, setup_data_s, tx_done_s})
    );

    logic tx_done_prev;
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            tok_v_prev <= 1'b0;
            tx_done_prev <= 1'b0;
        end else begin
            tok_v_prev <= tok_s[3];
            tx_done_prev <= tx_done_s;
        end
    end
    assign tok_v_p = tok_s[3] & ~tok_v_prev & ena_q;
    assign tx_done_p = tx_done_s & ~tx_done_prev & ena_q;

    // apb decode
    assign acc = PSEL & PENABLE;
    assign wr = acc & PWRITE;
    assign idx = (sel_q >= 3'h1 && sel_q <= 3'h5) ? sel_q - 3'h1 : 3'h0;
    assign release_w = wr && PADDR == ADDR_CTRL_CS && PWDATA[CS_RX_RELEASE];
    assign data_end_w = wr && PADDR == ADDR_CTRL_CS && PWDATA[CS_DATA_END];
    assign stall_w = wr && PADDR == ADDR_CTRL_CS && PWDATA[CS_SEND_STALL];
    assign abort_clr_w = wr && PADDR == ADDR_CTRL_CS && PWDATA[CS_ABORT_CLEAR];

    // token classification
    assign tok_in = tok_v_p && tok_s[2:1] == TOK_IN;
    assign tok_out = tok_v_p && tok_s[2:1] == TOK_OUT;
    assign tok_setup = tok_v_p && tok_s[2:1] == TOK_SETUP;
    assign stall_send = send_stall_q && (tok_in || tok_out);
    assign err = tok_v_p && (
        (st_q == EP0_STATUS_OUT && tok_out && !(tok_s[0] && tok_len_s == 10'h000)) ||
        (st_q == EP0_STATUS_OUT && tok_in) ||
        (st_q == EP0_STATUS_IN && tok_out) ||
        (st_q == EP0_RX && tok_out && data_end_q) ||
        (st_q == EP0_TX && tok_in && data_end_q && !tx_ready_q) ||
        (st_q == EP0_RX && tok_out && tok_len_s > EP0_MAX_PKT));
    assign abort = (st_q == EP0_TX && tok_out) || (st_q == EP0_RX && tok_in);
    assign nak = tok_in && !tx_ready_q && !err;
    assign ok_rx = (tok_setup && st_q == EP0_IDLE && tok_len_s == SETUP_LEN) ||
        (tok_out && st_q == EP0_RX && !rx_ready_q && !err);

    always_comb begin
        hs_d = HS_NONE;
        if (stall_send || err) begin
            hs_d = HS_STALL;
        end else if (tok_setup) begin
            hs_d = (ok_rx) ? HS_ACK : HS_NONE;
        end else if (tok_out) begin
            hs_d = (ok_rx || st_q == EP0_STATUS_OUT) ? HS_ACK : HS_NAK;
        end else if (tok_in && nak) begin
            hs_d = HS_NAK;
        end
    end

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            hs_q <= HS_NONE;
            hs_v_q <= 1'b0;
        end else begin
            hs_q <= hs_d;
            hs_v_q <= tok_v_p && (hs_d != HS_NONE);
        end
    end

    // enable and selection registers
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            ena_q <= 1'b0;
            irq_en_q <= 1'b0;
            sel_q <= 3'h0;
        end else begin
            if (wr && PADDR == ADDR_ENABLE) begin
                ena_q <= PWDATA[EN_BIT];
                irq_en_q <= PWDATA[EN_IRQ];
            end
            if (!ena_q) begin
                sel_q <= 3'h0;
            end else if (wr && PADDR == ADDR_EP_SELECT) begin
                sel_q <= PWDATA[2:0];
            end
        end
    end

    // control endpoint state machine
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            st_q <= EP0_IDLE;
            dir_in_q <= 1'b0;
            has_data_q <= 1'b0;
        end else if (!ena_q) begin
            st_q <= EP0_IDLE;
        end else begin
            case (st_q)
                EP0_IDLE: begin
                    if (tok_setup && ok_rx) begin
                        dir_in_q <= setup_in_s;
                        has_data_q <= setup_data_s;
                    end
                    if (release_w && !data_end_w && has_data_q) begin
                        st_q <= dir_in_q ? EP0_TX : EP0_RX;
                    end
                end
                EP0_TX: begin
                    if (err || stall_send || abort) begin
                        st_q <= EP0_IDLE;
                    end else if (tx_done_p && data_end_q) begin
                        st_q <= EP0_STATUS_OUT;
                    end
                end
                EP0_RX: begin
                    if (err || stall_send || abort) begin
                        st_q <= EP0_IDLE;
                    end else if (release_w && data_end_w) begin
                        st_q <= EP0_STATUS_IN;
                    end
                end
                EP0_STATUS_OUT: begin
                    if (tok_out || tok_setup || stall_send || err) begin
                        st_q <= EP0_IDLE;
                    end
                end
                EP0_STATUS_IN: begin
                    if (tx_done_p || err || stall_send || tok_setup) begin
                        st_q <= EP0_IDLE;
                    end
                end
                default: st_q <= EP0_IDLE;
            endcase
        end
    end

    // control endpoint flags; hardware set wins over software clear
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            rx_ready_q <= 1'b0;
            tx_ready_q <= 1'b0;
            sent_stall_q <= 1'b0;
            data_end_q <= 1'b0;
            aborted_q <= 1'b0;
            send_stall_q <= 1'b0;
            rx_count_q <= 10'h000;
        end else if (!ena_q) begin
            rx_ready_q <= 1'b0;
            tx_ready_q <= 1'b0;
            sent_stall_q <= 1'b0;
            data_end_q <= 1'b0;
            aborted_q <= 1'b0;
            send_stall_q <= 1'b0;
            rx_count_q <= 10'h000;
        end else begin
            if (ok_rx) begin
                rx_ready_q <= 1'b1;
                rx_count_q <= tok_len_s;
            end else if (release_w) begin
                rx_ready_q <= 1'b0;
            end
            if (tx_done_p && st_q == EP0_TX) begin
                tx_ready_q <= 1'b0;
            end else if (wr && PADDR == ADDR_CTRL_CS && PWDATA[CS_TXRDY]) begin
                tx_ready_q <= 1'b1;
            end
            if (stall_send || err) begin
                sent_stall_q <= 1'b1;
            end else if (wr && PADDR == ADDR_CTRL_CS && !PWDATA[CS_SENT_STALL]) begin
                sent_stall_q <= 1'b0;
            end
            if (data_end_w) begin
                data_end_q <= 1'b1;
            end else if (st_q != EP0_TX && st_q != EP0_RX) begin
                data_end_q <= 1'b0;
            end
            if (abort && tok_v_p) begin
                aborted_q <= 1'b1;
            end else if (abort_clr_w) begin
                aborted_q <= 1'b0;
            end
            if (stall_w) begin
                send_stall_q <= 1'b1;
            end else if (wr && PADDR == ADDR_CTRL_CS) begin
                send_stall_q <= 1'b0;
            end
        end
    end

    // interrupt pulse on any control endpoint event
    assign ev = ok_rx || (tx_done_p && st_q != EP0_IDLE) || stall_send || err ||
        (abort && tok_v_p);
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= ev && irq_en_q;
        end
    end

    // endpoints 1 to 5
    genvar g;
    generate
        for (g = 0; g < NUM_EP; g++) begin : g_ep
            usbep_epcfg #(.EP(g + 1)) u_ep (
                .clk(MCLK),
                .rst_n(RSTN),
                .ena(ena_q),
                .sel(sel_q == 3'(g + 1)),
                .wr_in_max(wr && PADDR == ADDR_IN_MAX),
                .wr_out_max(wr && PADDR == ADDR_OUT_MAX),
                .wr_in_cfg(wr && PADDR == ADDR_IN_CFG),
                .wr_out_cfg(wr && PADDR == ADDR_OUT_CFG),
                .wdata(PWDATA[9:0]),
                .in_max(in_max[g]),
                .out_max(out_max[g]),
                .in_cfg(in_cfg[g]),
                .out_cfg(out_cfg[g]),
                .layout_ok(lay_ok[g])
            );
        end
    endgenerate

    // read mux
    always_comb begin
        rd_d = 32'h0000_0000;
        case (PADDR)
            ADDR_CTRL_CS: rd_d = {26'h0, send_stall_q, aborted_q, data_end_q,
                sent_stall_q, tx_ready_q, rx_ready_q};
            ADDR_RX_COUNT: rd_d = {22'h0, rx_count_q};
            ADDR_EP_SELECT: rd_d = {29'h0, sel_q};
            ADDR_IN_MAX: rd_d = {22'h0, (sel_q == 3'h0) ? EP0_MAX_PKT : in_max[idx]};
            ADDR_OUT_MAX: rd_d = {22'h0, (sel_q == 3'h0) ? EP0_MAX_PKT : out_max[idx]};
            ADDR_IN_CFG: rd_d = {30'h0, (sel_q == 3'h0) ? 2'h0 : in_cfg[idx]};
            ADDR_OUT_CFG: rd_d = {30'h0, (sel_q == 3'h0) ? 2'h0 : out_cfg[idx]};
            ADDR_ENABLE: rd_d = {30'h0, irq_en_q, ena_q};
            ADDR_LAYOUT: rd_d = {27'h0, lay_ok};
            ADDR_EP0_FLAG: rd_d = {31'h0, irq_q};
            ADDR_EP0_STATE: rd_d = {29'h0, 3'(st_q)};
            default: rd_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            PRDATA <= 32'h0000_0000;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= PSEL & ~PENABLE;
            PRDATA <= (PSEL & ~PENABLE & ~PWRITE) ? rd_d : PRDATA;
            PSLVERR <= PSEL & ~PENABLE && PADDR > ADDR_EP0_STATE;
        end
    end

    assign HS_CODE = hs_q;
    assign HS_VALID = hs_v_q;
    assign EP0_IRQ = irq_q;
endmodule // usbep_ctrl

// file: inc/usbep_pkg.sv
package usbep_pkg;
    // apb register byte offsets
    localparam logic [7:0] ADDR_CTRL_CS = 8'h00;
    localparam logic [7:0] ADDR_RX_COUNT = 8'h04;
    localparam logic [7:0] ADDR_EP_SELECT = 8'h08;
    localparam logic [7:0] ADDR_IN_MAX = 8'h0c;
    localparam logic [7:0] ADDR_OUT_MAX = 8'h10;
    localparam logic [7:0] ADDR_IN_CFG = 8'h14;
    localparam logic [7:0] ADDR_OUT_CFG = 8'h18;
    localparam logic [7:0] ADDR_ENABLE = 8'h1c;
    localparam logic [7:0] ADDR_LAYOUT = 8'h20;
    localparam logic [7:0] ADDR_EP0_FLAG = 8'h24;
    localparam logic [7:0] ADDR_EP0_STATE = 8'h28;
    // ctrl_ep_control_status fields
    localparam int CS_RXRDY = 0;
    localparam int CS_TXRDY = 1;
    localparam int CS_SENT_STALL = 2;
    localparam int CS_DATA_END = 3;
    localparam int CS_SETUP_END = 4;
    localparam int CS_SEND_STALL = 5;
    localparam int CS_RX_RELEASE = 6;
    localparam int CS_ABORT_CLEAR = 7;
    // endpoint config fields
    localparam int CFG_ISO = 0;
    localparam int CFG_DBL = 1;
    // enable register field
    localparam int EN_BIT = 0;
    localparam int EN_IRQ = 1;
    // sizes
    localparam logic [9:0] EP0_MAX_PKT = 10'h020;
    localparam logic [9:0] SETUP_LEN = 10'h008;
    localparam logic [9:0] EP1_FIFO = 10'h020;
    localparam int NUM_EP = 5;
    // token and handshake codes
    localparam logic [1:0] TOK_SETUP = 2'h0;
    localparam logic [1:0] TOK_IN = 2'h1;
    localparam logic [1:0] TOK_OUT = 2'h2;
    localparam logic [1:0] HS_NONE = 2'h0;
    localparam logic [1:0] HS_ACK = 2'h1;
    localparam logic [1:0] HS_NAK = 2'h2;
    localparam logic [1:0] HS_STALL = 2'h3;
    typedef enum {EP0_IDLE, EP0_TX, EP0_RX, EP0_STATUS_IN, EP0_STATUS_OUT} usbep_state_t;
endpackage

// file: hw/usbep_epcfg.sv
`timescale 1ns/10ps
module usbep_epcfg
    import usbep_pkg::*;
#(
    parameter int EP = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ena,
    input wire logic sel,
    input wire logic wr_in_max,
    input wire logic wr_out_max,
    input wire logic wr_in_cfg,
    input wire logic wr_out_cfg,
    input wire logic [9:0] wdata,
    output logic [9:0] in_max,
    output logic [9:0] out_max,
    output logic [1:0] in_cfg,
    output logic [1:0] out_cfg,
    output logic layout_ok
);
    logic [10:0] fifo_size;
    logic [10:0] sum;
    // per-endpoint fifo size doubles each number
    assign fifo_size = {1'b0, EP1_FIFO} << (EP - 1);
    assign sum = {1'b0, in_max} + {1'b0, out_max};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            in_max <= 10'h000;
            out_max <= 10'h000;
            in_cfg <= 2'h0;
            out_cfg <= 2'h0;
        end else if (!ena) begin
            in_max <= 10'h000;
            out_max <= 10'h000;
            in_cfg <= 2'h0;
            out_cfg <= 2'h0;
        end else if (sel) begin
            if (wr_in_max) in_max <= wdata;
            if (wr_out_max) out_max <= wdata;
            if (wr_in_cfg) in_cfg <= wdata[1:0];
            if (wr_out_cfg) out_cfg <= wdata[1:0];
        end
    end

    // in grows down from top, out up from bottom; halves when double buffered
    assign layout_ok = (in_cfg[CFG_DBL] | out_cfg[CFG_DBL]) ?
        (sum <= (fifo_size >> 1)) : (sum <= fifo_size);
endmodule // usbep_epcfg

// file: hw/usbep_sync.sv
`timescale 1ns/10ps
module usbep_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= '0;
            q <= '0;
        end else begin
            s1_q <= d;
            q <= s1_q;
        end
    end
endmodule // usbep_sync

// file: dv/usbep_ctrl_assertions.sv
`timescale 1ns/10ps
module usbep_ctrl_assertions
    import usbep_pkg::*;
(
    input wire logic MCLK,
    input wire logic RSTN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic TOK_VALID,
    input wire logic [1:0] TOK_PID,
    input wire logic [9:0] TOK_LEN,
    input wire logic [1:0] HS_CODE,
    input wire logic HS_VALID,
    input wire logic EP0_IRQ
);
    logic en_q;
    logic ie_q;
    logic tv_q;
    logic [3:0] cnt_q;
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RSTN);
    // shadow of the enable register
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            en_q <= 1'b0;
            ie_q <= 1'b0;
        end else if (PSEL && PENABLE && PWRITE && PADDR == ADDR_ENABLE) begin
            en_q <= PWDATA[EN_BIT];
            ie_q <= PWDATA[EN_IRQ];
        end
    end
    // cycles since the last token strobe
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            tv_q <= 1'b0;
            cnt_q <= 4'hf;
        end else begin
            tv_q <= TOK_VALID;
            if (TOK_VALID && !tv_q) begin
                cnt_q <= 4'h0;
            end else if (cnt_q != 4'hf) begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end
    property p_hs_time;
        HS_VALID |-> cnt_q >= 4'h1 && cnt_q <= 4'h3;
    endproperty
    a_hs_time: assert property (p_hs_time) else $error("stray handshake");
    property p_setup_rej;
        $rose(TOK_VALID) && TOK_PID == TOK_SETUP && TOK_LEN != SETUP_LEN |=> !HS_VALID [*6];
    endproperty
    a_setup_rej: assert property (p_setup_rej) else $error("short setup answered");
    property p_off_quiet;
        $rose(TOK_VALID) && !en_q |=> !HS_VALID [*6];
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("disabled but answered");
    property p_stall_irq;
        HS_VALID && HS_CODE == HS_STALL && ie_q |-> EP0_IRQ;
    endproperty
    a_stall_irq: assert property (p_stall_irq) else $error("stall without irq");
    property p_irq_gate;
        EP0_IRQ |-> ie_q && en_q;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq while masked");
    property p_hs_pulse;
        HS_VALID |-> HS_CODE != HS_NONE ##1 !HS_VALID;
    endproperty
    a_hs_pulse: assert property (p_hs_pulse) else $error("handshake pulse bad");
    property p_ready;
        PSEL && !PENABLE |=> PREADY ##1 !PREADY;
    endproperty
    a_ready: assert property (p_ready) else $error("pready timing");
    property p_slverr;
        PREADY |-> PSLVERR == (PADDR > ADDR_EP0_STATE);
    endproperty
    a_slverr: assert property (p_slverr) else $error("pslverr wrong");
    property p_rst_quiet;
        $rose(RSTN) |-> !HS_VALID && !EP0_IRQ;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("output after reset");
endmodule // usbep_ctrl_assertions
bind usbep_ctrl usbep_ctrl_assertions chk_u (.MCLK, .RSTN, .PSEL, .PENABLE, .PWRITE, .PADDR,
    .PWDATA, .PREADY, .PSLVERR, .TOK_VALID, .TOK_PID, .TOK_LEN, .HS_CODE, .HS_VALID, .EP0_IRQ);

// file: dv/usbep_host.sv
`timescale 1ns/10ps
module usbep_host
    import usbep_pkg::*;
(
    input wire logic clk,
    input wire logic hs_valid,
    input wire logic [1:0] hs_code,
    input wire logic irq,
    output logic tok_valid,
    output logic [1:0] tok_pid,
    output logic tok_data1,
    output logic [9:0] tok_len,
    output logic dir_in,
    output logic has_data,
    output logic tx_done
);
    initial begin
        tok_valid = 1'b0;
        tok_pid = TOK_IN;
        tok_data1 = 1'b0;
        tok_len = 10'h000;
        dir_in = 1'b0;
        has_data = 1'b0;
        tx_done = 1'b0;
    end
    task automatic token(input logic [1:0] p, input logic d1, input logic [9:0] l,
            input logic di, input logic hd, output logic [1:0] c, output logic s);
        c = HS_NONE;
        s = 1'b0;
        @(posedge clk);
        tok_pid <= p;
        tok_data1 <= d1;
        tok_len <= l;
        dir_in <= di;
        has_data <= hd;
        tok_valid <= 1'b1;
        repeat (8) begin
            @(posedge clk);
            if (hs_valid === 1'b1) c = hs_code;
            if (irq === 1'b1) s = 1'b1;
        end
        // released lines carry garbage
        tok_valid <= 1'b0;
        tok_pid <= ~p;
        tok_data1 <= ~d1;
        tok_len <= ~l;
        dir_in <= ~di;
        has_data <= ~hd;
        repeat (4) @(posedge clk);
    endtask
    task automatic sent(output logic s);
        s = 1'b0;
        @(posedge clk);
        tx_done <= 1'b1;
        repeat (8) begin
            @(posedge clk);
            if (irq === 1'b1) s = 1'b1;
        end
        tx_done <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
endmodule // usbep_host

// file: dv/tb_usbep_ctrl.sv
`timescale 1ns/10ps
module tb_usbep_ctrl
    import usbep_pkg::*;
;
    logic mclk, rstn, psel, penable, pwrite, pready, pslverr, err, seen;
    logic tv, d1, din, hd, txd, hsv, irq;
    logic [1:0] pid, hsc, code;
    logic [9:0] len;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, f, lo;
    logic [1:0] fp[3];
    logic [9:0] fl[3];
    logic [1:0] fc[3];
    int n_mismatch = 0;
    int num_checks = 0;
    usbep_ctrl dut_u (.MCLK(mclk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .TOK_VALID(tv), .TOK_PID(pid), .TOK_DATA1(d1), .TOK_LEN(len),
        .SETUP_DIR_IN(din), .SETUP_HAS_DATA(hd), .TX_DONE(txd), .HS_CODE(hsc),
        .HS_VALID(hsv), .EP0_IRQ(irq));
    usbep_host host_u (.clk(mclk), .hs_valid(hsv), .hs_code(hsc), .irq(irq),
        .tok_valid(tv), .tok_pid(pid), .tok_data1(d1), .tok_len(len), .dir_in(din),
        .has_data(hd), .tx_done(txd));
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %0t value %h exp %h", $time, g, e);
        end
    endtask
    task automatic chkh(input logic [1:0] g, input logic [1:0] e);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %0t handshake %h exp %h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd & m, e);
    endtask
    task automatic tk(input logic [1:0] p, input logic d, input logic [9:0] l,
            input logic [1:0] e);
        host_u.token(p, d, l, 1'b0, 1'b0, code, seen);
        chkh(code, e);
    endtask
    task automatic stg(input logic di, input logic h, input logic [31:0] s);
        host_u.token(TOK_SETUP, 1'b0, SETUP_LEN, di, h, code, seen);
        chkh(code, HS_ACK);
        chk({31'h0, seen}, 32'h1);
        rdc(ADDR_CTRL_CS, 32'h1, 32'h1);
        rdc(ADDR_RX_COUNT, 32'h3ff, 32'h8);
        wr(ADDR_CTRL_CS, h ? 32'h40 : 32'h48);
        rdc(ADDR_EP0_STATE, 32'h7, s);
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        $display("ERROR %0t watchdog expired", $time);
        conclude();
    end
    initial begin
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        fp = '{TOK_IN, TOK_OUT, TOK_OUT};
        fl = '{10'h000, 10'h003, 10'h000};
        fc = '{HS_STALL, HS_STALL, HS_ACK};
        repeat (20) @(posedge mclk);
        rstn <= 1'b1;
        rdc(ADDR_CTRL_CS, 32'h3f, 32'h0);
        rdc(ADDR_EP0_STATE, 32'h7, 32'h0);
        tk(TOK_SETUP, 1'b0, SETUP_LEN, HS_NONE);
        wr(ADDR_ENABLE, 32'h3);
        tk(TOK_SETUP, 1'b0, 10'h007, HS_NONE);
        rdc(ADDR_CTRL_CS, 32'h1, 32'h0);
        for (int i = 0; i < 3; i++) begin
            stg(1'b1, 1'b1, 32'h1);
            tk(TOK_IN, 1'b0, 10'h000, HS_NAK);
            wr(ADDR_CTRL_CS, 32'h2);
            host_u.token(TOK_IN, 1'b0, 10'h000, 1'b0, 1'b0, code, seen);
            host_u.sent(seen);
            chk({31'h0, seen}, 32'h1);
            rdc(ADDR_CTRL_CS, 32'h2, 32'h0);
            wr(ADDR_CTRL_CS, 32'ha);
            host_u.token(TOK_IN, 1'b0, 10'h000, 1'b0, 1'b0, code, seen);
            host_u.sent(seen);
            tk(fp[i], 1'b1, fl[i], fc[i]);
            rdc(ADDR_CTRL_CS, 32'h4, fc[i] == HS_STALL ? 32'h4 : 32'h0);
        end
        rdc(ADDR_EP0_STATE, 32'h7, 32'h0);
        stg(1'b0, 1'b1, 32'h2);
        tk(TOK_OUT, 1'b0, 10'h021, HS_STALL);
        stg(1'b0, 1'b1, 32'h2);
        tk(TOK_OUT, 1'b1, 10'h020, HS_ACK);
        rdc(ADDR_RX_COUNT, 32'h3ff, 32'h20);
        wr(ADDR_CTRL_CS, 32'h40);
        host_u.token(TOK_IN, 1'b0, 10'h000, 1'b0, 1'b0, code, seen);
        rdc(ADDR_CTRL_CS, 32'h10, 32'h10);
        rdc(ADDR_EP0_STATE, 32'h7, 32'h0);
        wr(ADDR_CTRL_CS, 32'h80);
        rdc(ADDR_CTRL_CS, 32'h10, 32'h0);
        stg(1'b0, 1'b1, 32'h2);
        tk(TOK_OUT, 1'b0, 10'h005, HS_ACK);
        wr(ADDR_CTRL_CS, 32'h48);
        tk(TOK_OUT, 1'b1, 10'h000, HS_STALL);
        stg(1'b0, 1'b0, 32'h0);
        wr(ADDR_CTRL_CS, 32'h20);
        tk(TOK_IN, 1'b0, 10'h000, HS_STALL);
        rdc(ADDR_CTRL_CS, 32'h4, 32'h4);
        wr(ADDR_CTRL_CS, 32'h0);
        rdc(ADDR_CTRL_CS, 32'h24, 32'h0);
        stg(1'b0, 1'b1, 32'h2);
        tk(TOK_OUT, 1'b0, 10'h005, HS_ACK);
        wr(ADDR_ENABLE, 32'h2);
        rdc(ADDR_EP0_STATE, 32'h7, 32'h0);
        rdc(ADDR_CTRL_CS, 32'h1, 32'h0);
        rdc(ADDR_RX_COUNT, 32'h3ff, 32'h0);
        wr(ADDR_ENABLE, 32'h3);
        wr(ADDR_EP_SELECT, 32'h0);
        rdc(ADDR_IN_MAX, 32'h3ff, 32'h20);
        for (int e = 1; e <= NUM_EP; e++) begin
            f = 32'h20 << (e - 1);
            wr(ADDR_EP_SELECT, 32'(e));
            wr(ADDR_IN_MAX, f);
            wr(ADDR_OUT_MAX, 32'h0);
            apb(1'b0, ADDR_LAYOUT, 32'h0);
            lo = rd;
            wr(ADDR_OUT_MAX, 32'h1);
            apb(1'b0, ADDR_LAYOUT, 32'h0);
            chk(32'($countones(rd ^ lo)), 32'h1);
            wr(ADDR_OUT_MAX, 32'h0);
            wr(ADDR_IN_CFG, 32'h3);
            apb(1'b0, ADDR_LAYOUT, 32'h0);
            chk(32'($countones(rd ^ lo)), 32'h1);
            wr(ADDR_IN_MAX, f >> 1);
            rdc(ADDR_LAYOUT, 32'hffffffff, lo);
            rdc(ADDR_IN_CFG, 32'h3, 32'h3);
            rdc(ADDR_IN_MAX, 32'h3ff, f >> 1);
        end
        apb(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, err}, 32'h1);
        conclude();
    end
endmodule // tb_usbep_ctrl
